// ==== logic/chpc_pkg.sv ====
package chpc_pkg;

    // Clock rate in MHz, the cycle timing of one card write, and the card reset pulse and recovery times.
    localparam int CLK_MHZ = 50;
    localparam int SETUP_NS = 30;
    localparam int STROBE_NS = 80;
    localparam int HOLD_NS = 20;
    localparam int RESET_PULSE_NS = 10000;
    localparam int RECOVER_NS = 1000000;

    // Least times round up to whole cycles.
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;

    // Register offsets of the software port.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DMA_EN = 2;
    localparam int CTRL_HW_RESET = 3;

    // Command register fields.
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_ATTR = 20;
    localparam int CMD_SOFT_RESET = 21;

    // Status register fields.
    localparam int ST_BUSY = 0;
    localparam int ST_RESET_DONE = 1;
    localparam int ST_WAIT_SEEN = 2;
    localparam int ST_WP_LOW = 3;
    localparam int ST_PORT_WIDE = 4;
    localparam int ST_WORD_XFER = 5;
    localparam int ST_VS_ONE_LOW = 6;
    localparam int ST_VS_TWO_OPEN = 7;
    localparam int ST_DMA_ACTIVE = 8;
    localparam int ST_MODE_LSB = 9;

    // Configuration option register and its soft-reset bit.
    localparam logic [10:0] COR_ADDR = 11'h200;
    localparam logic [7:0] COR_SOFT_RESET = 8'h80;

    typedef enum logic [1:0] {
        MODE_MEM = 2'b00,
        MODE_IO = 2'b01,
        MODE_IDE = 2'b10
    } chpc_mode_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RESET = 3'b001,
        S_RECOVER = 3'b010,
        S_SETUP = 3'b011,
        S_STROBE = 3'b100,
        S_HOLD = 3'b101,
        S_DMA = 3'b110
    } chpc_state_t;

endpackage

// ==== logic/chpc_host.sv ====
// How it works
// - Attribute select high common, low attribute.
// - Select held low through I/O mode cycles.
// - DMA acknowledge answers card DMA request.
// - Acknowledge held high without DMA support.
// - Write-enable held high in IDE mode.
// - Mode select grounded to choose IDE mode.
module chpc_host #(
    parameter int RECOVER_CYCLES = chpc_pkg::RECOVER_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Software register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    // Card control pins
    output logic cardResetOut,
    output logic attrSelectN,
    output logic ideModeSelectN,
    output logic writeEnN,
    output logic chipEnN,
    output logic [10:0] cardAddr,
    output logic [7:0] cardDataOut,
    output logic cardDataOe,
    output logic dmaAcknowledgeN,
    // Card status pins
    input wire logic dmaRequest,
    input wire logic ioReadyOut,
    input wire logic sharedStatusN,
    input wire logic voltageSenseOne,
    input wire logic voltageSenseTwo
);

    chpc_pkg::chpc_state_t st_r;
    chpc_pkg::chpc_mode_t mode_r;
    chpc_pkg::chpc_mode_t newMode;
    logic [chpc_pkg::CNT_W-1:0] cnt_r;
    logic dmaEn_r;
    logic resetDone_r;
    logic waitSeen_r;
    logic cmdAttr_r;
    logic [10:0] cmdAddr_r;
    logic [7:0] cmdData_r;
    logic wrCtrl;
    logic wrCmd;
    logic startReset;
    logic cmdGo;
    logic dmaGo;
    logic isIde;
    logic inCycle;
    logic [31:0] statusWord;

    // Decode of software writes; a mode change always forces a card reset.
    assign wrCtrl = regWrStb && (regAddr == chpc_pkg::ADDR_CTRL);
    assign wrCmd = regWrStb && (regAddr == chpc_pkg::ADDR_CMD);
    assign isIde = (mode_r == chpc_pkg::MODE_IDE);
    assign newMode = (regWrData[chpc_pkg::CTRL_MODE_LSB+:2] == 2'h3) ? chpc_pkg::MODE_MEM :
                     chpc_pkg::chpc_mode_t'(regWrData[chpc_pkg::CTRL_MODE_LSB+:2]);
    assign startReset = wrCtrl && (regWrData[chpc_pkg::CTRL_HW_RESET] || (newMode != mode_r));
    // Commands are refused in IDE mode, where the write strobe is not used.
    assign cmdGo = wrCmd && (st_r == chpc_pkg::S_IDLE) && resetDone_r && !isIde;
    // Acknowledge is only ever given as the answer to a request.
    assign dmaGo = isIde && dmaEn_r && dmaRequest;
    assign inCycle = (st_r == chpc_pkg::S_SETUP) || (st_r == chpc_pkg::S_STROBE) || (st_r == chpc_pkg::S_HOLD);

    // Mode and DMA enable; mode only takes effect together with a reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= chpc_pkg::MODE_MEM;
            dmaEn_r <= 1'b0;
        end else if (wrCtrl) begin
            mode_r <= newMode;
            dmaEn_r <= regWrData[chpc_pkg::CTRL_DMA_EN];
        end
    end

    // Latch a command; in I/O mode every write goes to attribute space.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmdAttr_r <= 1'b0;
            cmdAddr_r <= 11'h000;
            cmdData_r <= 8'h00;
        end else if (cmdGo) begin
            if (regWrData[chpc_pkg::CMD_SOFT_RESET]) begin
                cmdAttr_r <= 1'b1;
                cmdAddr_r <= chpc_pkg::COR_ADDR;
                cmdData_r <= chpc_pkg::COR_SOFT_RESET;
            end else begin
                cmdAttr_r <= regWrData[chpc_pkg::CMD_ATTR] || (mode_r == chpc_pkg::MODE_IO);
                cmdAddr_r <= regWrData[chpc_pkg::CMD_ADDR_LSB+:11];
                cmdData_r <= regWrData[chpc_pkg::CMD_DATA_LSB+:8];
            end
        end
    end

    // Sequencer; the host resets the card from its own power-up onward.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= chpc_pkg::S_RESET;
            cnt_r <= chpc_pkg::CNT_W'(chpc_pkg::RESET_CYC - 1);
        end else if (startReset) begin
            st_r <= chpc_pkg::S_RESET;
            cnt_r <= chpc_pkg::CNT_W'(chpc_pkg::RESET_CYC - 1);
        end else begin
            case (st_r)
                chpc_pkg::S_IDLE: begin
                    if (cmdGo) begin
                        st_r <= chpc_pkg::S_SETUP;
                        cnt_r <= chpc_pkg::CNT_W'(chpc_pkg::SETUP_CYC - 1);
                    end else if (dmaGo) begin
                        st_r <= chpc_pkg::S_DMA;
                    end
                end
                chpc_pkg::S_RESET: begin
                    if (cnt_r == '0) begin
                        st_r <= chpc_pkg::S_RECOVER;
                        cnt_r <= chpc_pkg::CNT_W'(RECOVER_CYCLES - 1);
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                chpc_pkg::S_RECOVER: begin
                    if (cnt_r == '0) begin
                        st_r <= chpc_pkg::S_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                chpc_pkg::S_SETUP: begin
                    if (cnt_r == '0) begin
                        st_r <= chpc_pkg::S_STROBE;
                        cnt_r <= chpc_pkg::CNT_W'(chpc_pkg::STROBE_CYC - 1);
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                chpc_pkg::S_STROBE: begin
                    if (cnt_r == '0) begin
                        st_r <= chpc_pkg::S_HOLD;
                        cnt_r <= chpc_pkg::CNT_W'(chpc_pkg::HOLD_CYC - 1);
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                chpc_pkg::S_HOLD: begin
                    if (cnt_r == '0) begin
                        st_r <= chpc_pkg::S_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                chpc_pkg::S_DMA: begin
                    // The card drops its request to end the burst.
                    if (!dmaRequest || !dmaEn_r || !isIde) begin
                        st_r <= chpc_pkg::S_IDLE;
                    end
                end
                default: begin
                    st_r <= chpc_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Reset completion gates the pin-24 status, which is undefined earlier.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resetDone_r <= 1'b0;
        end else if (st_r == chpc_pkg::S_RESET || startReset) begin
            resetDone_r <= 1'b0;
        end else if (st_r == chpc_pkg::S_RECOVER && cnt_r == '0) begin
            resetDone_r <= 1'b1;
        end
    end

    // A card should never stretch a cycle, so any wait after reset completion is kept as a fault.
    // The set wins over a clear in the same cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitSeen_r <= 1'b0;
        end else if (resetDone_r && !ioReadyOut) begin
            waitSeen_r <= 1'b1;
        end else if (regWrStb && regAddr == chpc_pkg::ADDR_STATUS && regWrData[chpc_pkg::ST_WAIT_SEEN]) begin
            waitSeen_r <= 1'b0;
        end
    end

    // Reset pin polarity follows the selected mode.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cardResetOut <= 1'b1;
        end else if (st_r == chpc_pkg::S_RESET) begin
            cardResetOut <= !isIde;
        end else begin
            cardResetOut <= isIde;
        end
    end

    // Mode select and DMA acknowledge pins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ideModeSelectN <= 1'b1;
            dmaAcknowledgeN <= 1'b1;
        end else begin
            ideModeSelectN <= !isIde;
            // Held high whenever no DMA is running, as a non-DMA host must.
            dmaAcknowledgeN <= !(st_r == chpc_pkg::S_DMA);
        end
    end

    // Write cycle pins; outputs lag the sequencer by one cycle, widths kept.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            attrSelectN <= 1'b1;
            writeEnN <= 1'b1;
            chipEnN <= 1'b1;
            cardAddr <= 11'h000;
            cardDataOut <= 8'h00;
            cardDataOe <= 1'b0;
        end else begin
            attrSelectN <= !(inCycle && cmdAttr_r);
            writeEnN <= !(st_r == chpc_pkg::S_STROBE);
            chipEnN <= !inCycle;
            cardAddr <= inCycle ? cmdAddr_r : 11'h000;
            cardDataOut <= inCycle ? cmdData_r : 8'h00;
            cardDataOe <= inCycle;
        end
    end

    // Status word; pin 24 means a different thing in each mode.
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[chpc_pkg::ST_BUSY] = (st_r != chpc_pkg::S_IDLE);
        statusWord[chpc_pkg::ST_RESET_DONE] = resetDone_r;
        statusWord[chpc_pkg::ST_WAIT_SEEN] = waitSeen_r;
        statusWord[chpc_pkg::ST_WP_LOW] = resetDone_r && (mode_r == chpc_pkg::MODE_MEM) && !sharedStatusN;
        statusWord[chpc_pkg::ST_PORT_WIDE] = resetDone_r && (mode_r == chpc_pkg::MODE_IO) && !sharedStatusN;
        statusWord[chpc_pkg::ST_WORD_XFER] = resetDone_r && isIde && !sharedStatusN;
        statusWord[chpc_pkg::ST_VS_ONE_LOW] = !voltageSenseOne;
        statusWord[chpc_pkg::ST_VS_TWO_OPEN] = voltageSenseTwo;
        statusWord[chpc_pkg::ST_DMA_ACTIVE] = (st_r == chpc_pkg::S_DMA);
        statusWord[chpc_pkg::ST_MODE_LSB+:2] = mode_r;
    end

    // Read data stand in the cycle after the strobe only; unmapped reads give zero.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 32'h0000_0000;
        end else if (regRdStb) begin
            case (regAddr)
                chpc_pkg::ADDR_CTRL: begin
                    regRdData <= {28'h0000000, 1'b0, dmaEn_r, mode_r};
                end
                chpc_pkg::ADDR_STATUS: begin
                    regRdData <= statusWord;
                end
                default: begin
                    regRdData <= 32'h0000_0000;
                end
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_IDE_WE_HIGH: assert property (isIde && $past(isIde) |-> writeEnN)
        else $error("Write strobe pulsed in IDE mode.");
    AST_IO_WE_ATTR: assert property (!writeEnN && mode_r == chpc_pkg::MODE_IO |-> !attrSelectN)
        else $error("I/O mode write not aimed at configuration space.");
    AST_STROBE_WIDTH: assert property ($fell(writeEnN) |-> (!writeEnN)[*4] ##1 writeEnN)
        else $error("Write strobe width wrong.");
    AST_SPACE_STABLE: assert property (!writeEnN |-> $stable(attrSelectN) && !chipEnN)
        else $error("Space select moved during strobe.");
    AST_DMA_ACK_CAUSE: assert property ($fell(dmaAcknowledgeN) |-> $past(dmaRequest, 2))
        else $error("DMA acknowledge without a request.");
    AST_DMA_ACK_MODE: assert property (!isIde && !$past(isIde) |=> dmaAcknowledgeN)
        else $error("DMA acknowledge outside IDE mode.");
    AST_RESET_POL: assert property (st_r == chpc_pkg::S_RESET && $past(st_r) == chpc_pkg::S_RESET
        |=> cardResetOut == !$past(isIde))
        else $error("Reset pin polarity wrong for mode.");
    AST_RESET_HOLD: assert property ($rose(st_r == chpc_pkg::S_RESET) |=>
        (st_r == chpc_pkg::S_RESET)[*8])
        else $error("Card reset pulse too short.");
    AST_MODE_SEL: assert property ($past(isIde) && isIde |-> !ideModeSelectN)
        else $error("Mode select not grounded in IDE mode.");
    AST_MODE_RESET: assert property ($changed(mode_r) |-> st_r == chpc_pkg::S_RESET)
        else $error("Mode changed without card reset.");

    COV_MEM_WRITE: cover property ($fell(writeEnN) && mode_r == chpc_pkg::MODE_MEM);
    COV_IO_WRITE: cover property ($fell(writeEnN) && mode_r == chpc_pkg::MODE_IO);
    COV_DMA: cover property ($fell(dmaAcknowledgeN));
    COV_RESET_DONE: cover property ($rose(resetDone_r));

endmodule

// ==== bench/chpc_card_model.sv ====
module chpc_card_model (
    // Clock
    input wire logic clock,
    // Host pins
    input wire logic cardResetOut,
    input wire logic attrSelectN,
    input wire logic ideModeSelectN,
    input wire logic writeEnN,
    input wire logic chipEnN,
    input wire logic [10:0] cardAddr,
    input wire logic [7:0] cardDataOut,
    input wire logic cardDataOe,
    input wire logic dmaAcknowledgeN,
    // Card pins
    output logic dmaRequest,
    output logic ioReadyOut,
    output logic sharedStatusN,
    output logic voltageSenseOne,
    output logic voltageSenseTwo,
    // Bench controls and observations
    input wire logic cfgIo,
    input wire logic wide,
    input wire logic dmaWant,
    input wire logic badWait,
    output logic [10:0] lastAddr,
    output logic [7:0] lastData,
    output logic lastAttrN,
    output logic [7:0] softResets,
    output logic [7:0] nWr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ide = 1'b0;
    logic ready = 1'b0;
    logic weDly = 1'b1;
    logic resetActive;
    initial begin
        nWr = 8'h00;
        softResets = 8'h00;
    end
    // Polarity follows the live mode pin, because the host flips both pins together.
    assign resetActive = ideModeSelectN ? cardResetOut : !cardResetOut;
    // Mode is taken only while reset is active; writes land on the trailing edge of the strobe.
    always @(posedge clock) begin
        weDly <= writeEnN;
        if (resetActive) begin
            ide <= !ideModeSelectN;
            ready <= 1'b0;
        end else begin
            ready <= 1'b1;
        end
        if (!ide && !chipEnN && cardDataOe && writeEnN && !weDly && !(cfgIo && attrSelectN)) begin
            lastAddr <= cardAddr;
            lastData <= cardDataOut;
            lastAttrN <= attrSelectN;
            nWr <= nWr + 8'h01;
            if (!attrSelectN && cardAddr == chpc_pkg::COR_ADDR && cardDataOut[7]) begin
                softResets <= softResets + 8'h01;
                ready <= 1'b0;
            end
        end
    end
    // The acknowledge pin is never looked at, so a floating level cannot matter.
    assign dmaRequest = ide && ready && dmaWant;
    assign sharedStatusN = !ready ? 1'b1 : (ide || cfgIo) ? !wide : 1'b0;
    assign ioReadyOut = !badWait;
    assign voltageSenseOne = 1'b0;
    assign voltageSenseTwo = 1'b1;
endmodule

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [31:0] regRdData;
    logic cardResetOut, attrSelectN, ideModeSelectN, writeEnN, chipEnN, cardDataOe, dmaAcknowledgeN;
    logic [10:0] cardAddr, lastAddr;
    logic [7:0] cardDataOut, lastData, softResets, nWr;
    logic dmaRequest, ioReadyOut, sharedStatusN, voltageSenseOne, voltageSenseTwo, lastAttrN;
    logic cfgIo = 1'b0;
    logic wide = 1'b0;
    logic dmaWant = 1'b0;
    logic badWait = 1'b0;
    logic [31:0] seed = 32'h17F09DB3;
    int errors = 0;
    int n_compared = 0;

    // Recovery is shortened so that each card reset costs about 520 cycles.
    chpc_host #(.RECOVER_CYCLES(20)) chpc_host_i (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .cardResetOut(cardResetOut), .attrSelectN(attrSelectN), .ideModeSelectN(ideModeSelectN),
        .writeEnN(writeEnN), .chipEnN(chipEnN), .cardAddr(cardAddr), .cardDataOut(cardDataOut),
        .cardDataOe(cardDataOe), .dmaAcknowledgeN(dmaAcknowledgeN), .dmaRequest(dmaRequest),
        .ioReadyOut(ioReadyOut), .sharedStatusN(sharedStatusN), .voltageSenseOne(voltageSenseOne),
        .voltageSenseTwo(voltageSenseTwo));
    chpc_card_model chpc_card_model_i (.clock(clock), .cardResetOut(cardResetOut), .attrSelectN(attrSelectN),
        .ideModeSelectN(ideModeSelectN), .writeEnN(writeEnN), .chipEnN(chipEnN), .cardAddr(cardAddr),
        .cardDataOut(cardDataOut), .cardDataOe(cardDataOe), .dmaAcknowledgeN(dmaAcknowledgeN), .dmaRequest(dmaRequest),
        .ioReadyOut(ioReadyOut), .sharedStatusN(sharedStatusN), .voltageSenseOne(voltageSenseOne),
        .voltageSenseTwo(voltageSenseTwo), .cfgIo(cfgIo), .wide(wide), .dmaWant(dmaWant), .badWait(badWait),
        .lastAddr(lastAddr), .lastData(lastData), .lastAttrN(lastAttrN), .softResets(softResets), .nWr(nWr));

    // Free-running 50 MHz clock.
    always #10 clock = ~clock;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected status word for a settled card in the given mode; a running DMA keeps the host busy.
    function automatic logic [31:0] stat_exp(input logic [1:0] m, input logic w, input logic dma);
        logic [31:0] e;
        e = 32'h00000002;
        e[0] = dma;
        e[3] = (m == 2'b00);
        e[4] = (m == 2'b01) && w;
        e[5] = (m == 2'b10) && w;
        e[7:6] = 2'b11;
        e[8] = dma;
        e[10:9] = m;
        return e;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clock);
        regWrStb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clock);
        regRdStb <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic wait_ready();
        logic [31:0] s;
        for (int i = 0; i < 3000; i++) begin
            rd(chpc_pkg::ADDR_STATUS, s);
            if (s[1] === 1'b1 && s[0] === 1'b0) break;
        end
        // A card that never settles is a failure, not a silent fall-through.
        if (s[1] !== 1'b1 || s[0] !== 1'b0) errors++;
    endtask
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the three card resets of the run.
    initial begin
        #400000;
        errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] r;
        logic [7:0] n;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(chpc_pkg::ADDR_CTRL, r);
        chk(r, 32'h0);
        wait_ready();
        rd(8'h0C, r);
        chk(r, 32'h0);
        rd(chpc_pkg::ADDR_CMD, r);
        chk(r, 32'h0);
        rd(chpc_pkg::ADDR_STATUS, r);
        chk(r, stat_exp(2'b00, 1'b0, 1'b0));
        // Random byte writes, kept below the option register so they cannot reset the card.
        for (int k = 0; k < 6; k++) begin
            v = xs() & 32'h0011FFFF;
            wr(chpc_pkg::ADDR_CMD, v);
            wait_ready();
            chk(lastAddr, v[18:8]);
            chk(lastData, v[7:0]);
            chk(lastAttrN, !v[20]);
        end
        n = softResets;
        wr(chpc_pkg::ADDR_CMD, 32'h00200000);
        wait_ready();
        chk(softResets, n + 8'h01);
        chk(lastAddr, chpc_pkg::COR_ADDR);
        chk(lastData, chpc_pkg::COR_SOFT_RESET);
        @(posedge clock);
        badWait <= 1'b1;
        repeat (3) @(posedge clock);
        badWait <= 1'b0;
        rd(chpc_pkg::ADDR_STATUS, r);
        chk(r[2], 1'b1);
        wr(chpc_pkg::ADDR_STATUS, 32'h00000004);
        rd(chpc_pkg::ADDR_STATUS, r);
        chk(r[2], 1'b0);
        // I/O mode: a common-space request must still reach the card as an attribute write.
        cfgIo <= 1'b1;
        wide <= 1'b1;
        wr(chpc_pkg::ADDR_CTRL, 32'h1);
        wait_ready();
        rd(chpc_pkg::ADDR_STATUS, r);
        chk(r, stat_exp(2'b01, 1'b1, 1'b0));
        wr(chpc_pkg::ADDR_CMD, 32'h000055A5);
        wait_ready();
        chk(lastAttrN, 1'b0);
        chk(lastData, 8'hA5);
        // True IDE mode with DMA: writes are refused and the reset pin turns round.
        cfgIo <= 1'b0;
        n = nWr;
        wr(chpc_pkg::ADDR_CTRL, 32'h6);
        wait_ready();
        chk(ideModeSelectN, 1'b0);
        chk(cardResetOut, 1'b1);
        wr(chpc_pkg::ADDR_CMD, 32'h00001234);
        repeat (12) @(posedge clock);
        #1;
        chk(nWr, n);
        chk(cardDataOe, 1'b0);
        chk(writeEnN, 1'b1);
        dmaWant <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chk(dmaAcknowledgeN, 1'b0);
        rd(chpc_pkg::ADDR_STATUS, r);
        chk(r, stat_exp(2'b10, 1'b1, 1'b1));
        @(posedge clock);
        dmaWant <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk(dmaAcknowledgeN, 1'b1);
        report_and_stop();
    end
endmodule
